// ==== core/usbsb_pkg.sv ====
// Package with constants and carrier types for the bridge bring-up sequencer
package usbsb_pkg;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_BOOT_REQ,
    ST_BOOT_WAIT,
    ST_SATA_RST,
    ST_SATA_OOB,
    ST_SIG_WAIT,
    ST_IDENT,
    ST_DRV_CFG,
    ST_USB_CFG,
    ST_VBUS_WAIT,
    ST_SS_TRAIN,
    ST_HSFS,
    ST_READY,
    ST_NO_DRIVE
  } usbsb_state_t;

  // Negotiated SATA link rates
  localparam logic [1:0] SATA_RATE_NONE = 2'h0;
  localparam logic [1:0] SATA_RATE_1G5 = 2'h1;
  localparam logic [1:0] SATA_RATE_3G0 = 2'h2;

  // USB connection speeds
  localparam logic [1:0] USB_SPD_NONE = 2'h0;
  localparam logic [1:0] USB_SPD_FS = 2'h1;
  localparam logic [1:0] USB_SPD_HS = 2'h2;
  localparam logic [1:0] USB_SPD_SS = 2'h3;

  // Interface alternate settings: bulk-only primary, UASP as alternate 1
  localparam logic [7:0] ALT_BOT = 8'h00;
  localparam logic [7:0] ALT_UASP = 8'h01;

  // Width of the stored drive signature
  localparam int SIG_W = 32;

  // Timing: port reset pulse and SuperSpeed training timeout
  localparam int CLK_MHZ = 200;
  localparam int PORT_RST_NS = 1000;
  localparam int PORT_RST_CYC = (PORT_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int SS_TRAIN_US = 360000;
  localparam int SS_TRAIN_CYC_DEF = SS_TRAIN_US * CLK_MHZ;
  localparam int CNT_W = 32;

  // Requests from the sequencer to its helpers, one-cycle pulses
  typedef struct packed {
    logic boot_start;
    logic ident_start;
    logic drv_cfg_start;
    logic usb_cfg_start;
  } usbsb_req_t;

  // Completions from the helpers, one-cycle pulses
  typedef struct packed {
    logic boot_done;
    logic ident_done;
    logic drv_cfg_done;
    logic usb_cfg_done;
  } usbsb_done_t;

  // SATA link status from the adapter's link layer
  typedef struct packed {
    logic oob_done;
    logic drive_found;
    logic [1:0] rate;
    logic fis_valid;
    logic [SIG_W-1:0] fis_sig;
  } usbsb_sata_t;

endpackage

// ==== core/usbsb_seq.sv ====
// Bring-up sequencer for the USB to SATA bridge
//
// What this block does
// - After reset release, load firmware from serial flash before any other setup.
// - Adapter setup issues a port reset, starting OOB detection and 3.0/1.5 Gbps choice.
// - Attach to USB only after USB setup, drive found, and VBUS present.
// - Try SuperSpeed first; on training timeout enable DP pull-up, attach HS/FS.
// - Bulk-only is primary interface; alternate setting 1 selects UASP.
// - First device-to-host FIS after negotiation is stored as port signature.
// - On drive connection issue IDENTIFY DEVICE, then configure drive features.
// - USB setup builds descriptors, endpoints, request-block memory and request blocks.
`timescale 1ns/1ps

module usbsb_seq #(
  parameter int SS_TRAIN_CYC = usbsb_pkg::SS_TRAIN_CYC_DEF
) (
  input wire logic sys_clk,
  input wire logic rst,
  // Pin reset, far-side status and host requests
  input wire logic global_reset_n,
  input wire usbsb_pkg::usbsb_done_t done_i,
  input wire usbsb_pkg::usbsb_sata_t sata_i,
  input wire logic vbus_present,
  input wire logic ss_train_ok,
  input wire logic upstream_hs,
  input wire logic set_if_valid,
  input wire logic [7:0] set_if_alt,
  // Registered outputs, each one a field of the state record
  output logic [3:0] req_o,
  output logic port_reset,
  output logic [usbsb_pkg::SIG_W-1:0] port_signature,
  output logic sig_valid,
  output logic [1:0] sata_rate,
  output logic ss_enable,
  output logic dp_pullup,
  output logic [1:0] usb_speed,
  output logic uasp_active,
  output logic no_drive,
  output logic ready
);

  // Whole state of the sequencer, one record
  typedef struct packed {
    usbsb_pkg::usbsb_state_t st;
    logic [usbsb_pkg::CNT_W-1:0] cnt;
    usbsb_pkg::usbsb_req_t req;
    logic port_reset;
    logic [usbsb_pkg::SIG_W-1:0] sig;
    logic sig_valid;
    logic [1:0] rate;
    logic drive_found;
    logic ss_enable;
    logic dp_pullup;
    logic [1:0] usb_speed;
    logic uasp;
    logic no_drive;
    logic ready;
  } usbsb_reg_t;

  usbsb_reg_t s_r;
  usbsb_reg_t s_nxt;

  // Alternate setting decode; anything but 1 falls back to bulk-only
  function automatic logic alt_is_uasp(input logic [7:0] alt);
    alt_is_uasp = (alt == usbsb_pkg::ALT_UASP);
  endfunction

  // Next-state logic; requests are single-cycle pulses
  always_comb begin
    s_nxt = s_r;
    s_nxt.req = '0;
    // Counter runs freely; each timed wait zeroes it on entry
    s_nxt.cnt = s_r.cnt + 32'h1;
    case (s_r.st)
      usbsb_pkg::ST_BOOT_REQ: begin
        // Global reset pin held low keeps everything parked
        if (global_reset_n) begin
          s_nxt.req.boot_start = 1'b1;
          s_nxt.st = usbsb_pkg::ST_BOOT_WAIT;
        end
      end
      usbsb_pkg::ST_BOOT_WAIT: begin
        // Nothing else is configured until the image is in RAM
        if (done_i.boot_done) begin
          s_nxt.st = usbsb_pkg::ST_SATA_RST;
          s_nxt.cnt = '0;
          s_nxt.port_reset = 1'b1;
        end
      end
      usbsb_pkg::ST_SATA_RST: begin
        // Pulse width is fixed; the OOB exchange starts as it ends
        if (s_r.cnt >= 32'(usbsb_pkg::PORT_RST_CYC - 1)) begin
          s_nxt.port_reset = 1'b0;
          s_nxt.st = usbsb_pkg::ST_SATA_OOB;
        end
      end
      usbsb_pkg::ST_SATA_OOB: begin
        // An empty port still completes OOB, only without a drive
        if (sata_i.oob_done) begin
          s_nxt.drive_found = sata_i.drive_found;
          s_nxt.rate = sata_i.drive_found ? sata_i.rate : usbsb_pkg::SATA_RATE_NONE;
          s_nxt.st = sata_i.drive_found ? usbsb_pkg::ST_SIG_WAIT : usbsb_pkg::ST_USB_CFG;
        end
      end
      usbsb_pkg::ST_SIG_WAIT: begin
        // Only the first FIS is kept as the signature
        if (sata_i.fis_valid && !s_r.sig_valid) begin
          s_nxt.sig = sata_i.fis_sig;
          s_nxt.sig_valid = 1'b1;
          s_nxt.req.ident_start = 1'b1;
          s_nxt.st = usbsb_pkg::ST_IDENT;
        end
      end
      usbsb_pkg::ST_IDENT: begin
        // Drive features are set only once its capabilities are known
        if (done_i.ident_done) begin
          s_nxt.req.drv_cfg_start = 1'b1;
          s_nxt.st = usbsb_pkg::ST_DRV_CFG;
        end
      end
      usbsb_pkg::ST_DRV_CFG: begin
        // USB side is set up last, so the host never meets an unready drive
        if (done_i.drv_cfg_done) begin
          s_nxt.req.usb_cfg_start = 1'b1;
          s_nxt.st = usbsb_pkg::ST_USB_CFG;
        end
      end
      usbsb_pkg::ST_USB_CFG: begin
        // No-drive path enters here without a request and parks detached
        if (!s_r.drive_found) begin
          s_nxt.no_drive = 1'b1;
          s_nxt.st = usbsb_pkg::ST_NO_DRIVE;
        end else if (done_i.usb_cfg_done) begin
          s_nxt.st = usbsb_pkg::ST_VBUS_WAIT;
        end
      end
      usbsb_pkg::ST_VBUS_WAIT: begin
        // Drive check repeated so that no path can attach without one
        if (vbus_present && s_r.drive_found) begin
          s_nxt.ss_enable = 1'b1;
          s_nxt.cnt = '0;
          s_nxt.st = usbsb_pkg::ST_SS_TRAIN;
        end
      end
      usbsb_pkg::ST_SS_TRAIN: begin
        if (!vbus_present) begin
          s_nxt.ss_enable = 1'b0;
          s_nxt.st = usbsb_pkg::ST_VBUS_WAIT;
        end else if (ss_train_ok) begin
          s_nxt.usb_speed = usbsb_pkg::USB_SPD_SS;
          s_nxt.ready = 1'b1;
          s_nxt.st = usbsb_pkg::ST_READY;
        end else if (s_r.cnt >= 32'(SS_TRAIN_CYC - 1)) begin
          // Timeout: drop SuperSpeed, present the pull-up instead
          s_nxt.ss_enable = 1'b0;
          s_nxt.dp_pullup = 1'b1;
          s_nxt.st = usbsb_pkg::ST_HSFS;
        end
      end
      usbsb_pkg::ST_HSFS: begin
        // Pull-up is already on; the speed follows the upstream port
        s_nxt.usb_speed = upstream_hs ? usbsb_pkg::USB_SPD_HS : usbsb_pkg::USB_SPD_FS;
        s_nxt.ready = 1'b1;
        s_nxt.st = usbsb_pkg::ST_READY;
      end
      usbsb_pkg::ST_READY: begin
        // Host picks the interface; bulk-only until alternate 1 is chosen
        if (set_if_valid) begin
          s_nxt.uasp = alt_is_uasp(set_if_alt);
        end
        if (!vbus_present) begin
          // Loss of VBUS detaches and returns to waiting
          s_nxt.ss_enable = 1'b0;
          s_nxt.dp_pullup = 1'b0;
          s_nxt.usb_speed = usbsb_pkg::USB_SPD_NONE;
          s_nxt.uasp = 1'b0;
          s_nxt.ready = 1'b0;
          s_nxt.st = usbsb_pkg::ST_VBUS_WAIT;
        end
      end
      usbsb_pkg::ST_NO_DRIVE: begin
        // Parked until a reset; attach outputs are forced off every cycle
        s_nxt.ss_enable = 1'b0;
        s_nxt.dp_pullup = 1'b0;
      end
      default: begin
        // Unused state codes restart the bring-up
        s_nxt.st = usbsb_pkg::ST_BOOT_REQ;
      end
    endcase
    // Pin reset restarts the whole bring-up, relying on the outside hold time
    if (!global_reset_n) begin
      s_nxt = '0;
      s_nxt.st = usbsb_pkg::ST_BOOT_REQ;
    end
  end

  // State register; rst clears it at once
  // The pin reset acts through the next-state logic, so it is synchronous
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state record
  assign req_o = s_r.req;
  assign port_reset = s_r.port_reset;
  assign port_signature = s_r.sig;
  assign sig_valid = s_r.sig_valid;
  assign sata_rate = s_r.rate;
  assign ss_enable = s_r.ss_enable;
  assign dp_pullup = s_r.dp_pullup;
  assign usb_speed = s_r.usb_speed;
  assign uasp_active = s_r.uasp;
  assign no_drive = s_r.no_drive;
  assign ready = s_r.ready;

endmodule

// ==== sim/usb_sata_bridge_bringup_sequencer_tb_top.sv ====
// Self-checking bench for the bring-up sequencer
`timescale 1ns/1ps
module usb_sata_bridge_bringup_sequencer_tb_top;
  logic sys_clk = 1'b0;
  logic rst, global_reset_n, vbus_present, ss_train_ok, upstream_hs, set_if_valid, drive_on;
  logic port_reset, sig_valid, ss_enable, dp_pullup, uasp_active, no_drive, ready;
  logic [7:0] set_if_alt;
  logic [1:0] rate, lat, sata_rate, usb_speed;
  logic [31:0] sig, seed, port_signature;
  logic [3:0] req_o;
  usbsb_pkg::usbsb_done_t done_i;
  usbsb_pkg::usbsb_sata_t sata_i;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  usbsb_seq #(.SS_TRAIN_CYC(50)) DUT (
    .sys_clk(sys_clk),
    .rst(rst),
    .global_reset_n(global_reset_n),
    .done_i(done_i),
    .sata_i(sata_i),
    .vbus_present(vbus_present),
    .ss_train_ok(ss_train_ok),
    .upstream_hs(upstream_hs),
    .set_if_valid(set_if_valid),
    .set_if_alt(set_if_alt),
    .req_o(req_o),
    .port_reset(port_reset),
    .port_signature(port_signature),
    .sig_valid(sig_valid),
    .sata_rate(sata_rate),
    .ss_enable(ss_enable),
    .dp_pullup(dp_pullup),
    .usb_speed(usb_speed),
    .uasp_active(uasp_active),
    .no_drive(no_drive),
    .ready(ready)
  );
  usbsb_partner u_far (
    .sys_clk(sys_clk),
    .rst(rst),
    .req_o(req_o),
    .port_reset(port_reset),
    .drive_on(drive_on),
    .rate(rate),
    .lat(lat),
    .sig(sig),
    .done_i(done_i),
    .sata_i(sata_i)
  );
  always #2.5 sys_clk = ~sys_clk;
  // Guard against a hang; each run needs well under 400 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [1:0] exp_speed(input logic ss, input logic hs);
    return ss ? usbsb_pkg::USB_SPD_SS : (hs ? usbsb_pkg::USB_SPD_HS : usbsb_pkg::USB_SPD_FS);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Runs 0..3 are fixed corners: SS, no drive, HS fallback, FS fallback
  task automatic run_one(input int i);
    logic [31:0] r;
    logic ss;
    int w;
    r = rnd();
    ss = (i == 0) || (i > 3 && r[2]);
    @(posedge sys_clk);
    global_reset_n <= 1'b0;
    vbus_present <= 1'b0;
    drive_on <= (i != 1) && (i < 4 || r[0] || r[1]);
    ss_train_ok <= ss;
    upstream_hs <= (i == 2) || (i > 3 && r[3]);
    lat <= r[5:4];
    rate <= r[6] ? usbsb_pkg::SATA_RATE_3G0 : usbsb_pkg::SATA_RATE_1G5;
    sig <= rnd();
    set_if_alt <= r[7] ? usbsb_pkg::ALT_UASP : r[15:8];
    repeat (4) @(posedge sys_clk);
    global_reset_n <= 1'b1;
    w = 0;
    // VBUS may show up before USB setup ends; attach must still wait
    while (ready !== 1'b1 && no_drive !== 1'b1 && w < 2000) begin
      @(posedge sys_clk);
      if (w == 200 + int'(r[21:16])) vbus_present <= 1'b1;
      w++;
      #1;
    end
    chk(32'({ready, no_drive}), 32'({drive_on, !drive_on}));
    if (drive_on) begin
      chk(32'(sata_rate), 32'(rate));
      chk(port_signature, sig);
      chk(32'({dp_pullup, usb_speed}), 32'({!ss, exp_speed(ss, upstream_hs)}));
      chk(32'(uasp_active), 32'h0);
      @(posedge sys_clk);
      set_if_valid <= 1'b1;
      @(posedge sys_clk);
      set_if_valid <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk(32'(uasp_active), 32'(set_if_alt == usbsb_pkg::ALT_UASP));
    end else begin
      chk(32'({ss_enable, dp_pullup, usb_speed}), 32'h0);
    end
  endtask
  initial begin
    rst = 1'b1;
    global_reset_n = 1'b0;
    {vbus_present, ss_train_ok, upstream_hs, set_if_valid, drive_on} = '0;
    {set_if_alt, rate, lat, sig} = '0;
    seed = 32'hae69;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) run_one(i);
    tally_and_finish();
  end
endmodule

// ==== sim/usbsb_chk.sv ====
// Port checker for the bring-up sequencer
`timescale 1ns/1ps
module usbsb_chk #(
  parameter int SS_TRAIN_CYC = 50
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic global_reset_n,
  input wire usbsb_pkg::usbsb_done_t done_i,
  input wire usbsb_pkg::usbsb_sata_t sata_i,
  input wire logic vbus_present,
  input wire logic ss_train_ok,
  input wire logic upstream_hs,
  input wire logic set_if_valid,
  input wire logic [7:0] set_if_alt,
  input wire logic [3:0] req_o,
  input wire logic port_reset,
  input wire logic [31:0] port_signature,
  input wire logic sig_valid,
  input wire logic ss_enable,
  input wire logic dp_pullup,
  input wire logic [1:0] usb_speed,
  input wire logic uasp_active,
  input wire logic no_drive,
  input wire logic ready
);
  logic [15:0] pr_cnt_r;
  logic [31:0] tr_cnt_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst || !global_reset_n);
  // Length of the current port reset pulse and of the current SuperSpeed attempt
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pr_cnt_r <= '0;
      tr_cnt_r <= '0;
    end else begin
      pr_cnt_r <= port_reset ? pr_cnt_r + 16'h1 : 16'h0;
      tr_cnt_r <= (ss_enable && !ready) ? tr_cnt_r + 32'h1 : 32'h0;
    end
  end
  boot_first_a: assert property ($rose(global_reset_n) |-> ##[1:2] req_o[3])
    else $error("boot request missing after reset release");
  rst_width_a: assert property ($fell(port_reset) |-> pr_cnt_r == usbsb_pkg::PORT_RST_CYC)
    else $error("port reset width wrong");
  sig_first_a: assert property (sata_i.fis_valid && !sig_valid |=>
    sig_valid && req_o[2] && port_signature == $past(sata_i.fis_sig))
    else $error("first signature not stored");
  ident_next_a: assert property (done_i.ident_done |=> req_o[1])
    else $error("drive setup not started");
  attach_gate_a: assert property ($rose(ss_enable) |-> $past(vbus_present) && sig_valid)
    else $error("attach without vbus or drive");
  ss_win_a: assert property (ss_enable && ss_train_ok |=> ready && usb_speed == 2'h3)
    else $error("superspeed success not taken");
  fallback_a: assert property ($fell(ss_enable) && !ready |-> dp_pullup ##1
    (ready && usb_speed == (upstream_hs ? 2'h2 : 2'h1)))
    else $error("fallback attach wrong");
  ss_timeout_a: assert property ($fell(ss_enable) && dp_pullup && !ready |->
    tr_cnt_r == 32'(SS_TRAIN_CYC))
    else $error("superspeed timeout length wrong");
  uasp_sel_a: assert property (set_if_valid && ready |=> uasp_active == (set_if_alt == 8'h01))
    else $error("alternate setting not applied");
  no_drive_a: assert property (no_drive |-> !ss_enable && !dp_pullup && !ready)
    else $error("signalling while no drive");
  cover property (ready && usb_speed == 2'h3);
  cover property (ready && dp_pullup);
  cover property (no_drive);
  cover property (ready && uasp_active);
endmodule
bind usbsb_seq usbsb_chk #(.SS_TRAIN_CYC(SS_TRAIN_CYC)) u_chk (.*);

// ==== sim/usbsb_partner.sv ====
// Far-side model: firmware helpers and a SATA drive
`timescale 1ns/1ps
module usbsb_partner (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] req_o,
  input wire logic port_reset,
  input wire logic drive_on,
  input wire logic [1:0] rate,
  input wire logic [1:0] lat,
  input wire logic [31:0] sig,
  output usbsb_pkg::usbsb_done_t done_i,
  output usbsb_pkg::usbsb_sata_t sata_i
);
  logic [15:0] sh_r;
  logic pr_r;
  logic f1_r;
  // Helpers answer a few cycles late; a second FIS carries a wrong signature
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sh_r <= '0;
      pr_r <= 1'b0;
      f1_r <= 1'b0;
      done_i <= '0;
      sata_i <= '0;
    end else begin
      sh_r <= {sh_r[11:0], req_o};
      done_i <= sh_r[lat*4 +: 4];
      pr_r <= port_reset;
      sata_i.oob_done <= pr_r & ~port_reset;
      sata_i.drive_found <= drive_on;
      sata_i.rate <= drive_on ? rate : usbsb_pkg::SATA_RATE_NONE;
      f1_r <= sata_i.oob_done & drive_on;
      sata_i.fis_valid <= (sata_i.oob_done & drive_on) | f1_r;
      sata_i.fis_sig <= sata_i.oob_done ? sig : ~sig;
    end
  end
endmodule
